//--- rtl/aofr_top.sv
// Output frame composer with range and reference settings
// Operation
// - Supply-alarm selector appends high/low/both flags
// - Input-alarm selector appends high/low/both flags
// - Span-append bit adds four-bit span code
// - Parity enable appends result then frame parity
// - Result parity is even over result only
// - Frame parity is even over frame ahead of both parity bits
// - Result parity bit excluded from frame parity
// - Parity lengthens frame by exactly two bits
// - Selector MSB zero passes real result
// - Codes 100/101/110 give zeros/ones/alternating
// - Code 111 gives alternating bit pairs
// - Reference-off bit one disables onchip reference
// - Codes 0-4 select five bipolar spans
// - Codes 8-11 select four unipolar spans
// - Span and parity cleared only at power-on
// - Reserved bits ignore writes, read zero
// - Identifier append bit adds four-bit identifier
//
// The Wishbone register port was decided locally.
`timescale 1ns/100ps
`default_nettype none
module aofr_top
  import aofr_pkg::*;
(
  input wire logic clk,
  input wire logic arst_n,
  input wire logic app_rst_n,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  input wire logic conv_valid,
  input wire logic [RES_W-1:0] conv_result,
  input wire logic supply_high_flag,
  input wire logic supply_low_flag,
  input wire logic input_high_flag,
  input wire logic input_low_flag,
  output logic conv_ready,
  output logic frame_valid,
  output logic [FRAME_W-1:0] frame_bits,
  output logic [LEN_W-1:0] frame_len,
  input wire logic frame_ready,
  output logic onchip_reference_off,
  output logic [3:0] span_code
);
  // Frame control fields
  logic [1:0] supply_alarm_append_sel;
  logic [1:0] input_alarm_append_sel;
  logic span_code_append;
  logic parity_append_enable;
  logic [2:0] output_value_selector;
  logic chip_identifier_append;
  logic [3:0] chip_id;
  // Application reset synchroniser
  logic app_meta;
  logic app_sync;
  logic app_rst;
  // Bus decode
  logic wb_req;
  logic wr_frame;
  logic wr_range;
  logic wr_chip;
  logic [7:0] word_adr;
  logic [31:0] next_rdata;
  // Captured conversion
  logic [RES_W-1:0] hold_result;
  logic [3:0] hold_flags;
  logic [FRAME_W-1:0] pk_frame;
  logic [LEN_W-1:0] pk_len;
  logic [RES_W-1:0] pk_shown;
  logic [FIFO_LVL_W-1:0] fifo_level;
  logic [LEN_W-1:0] exp_len;

  aofr_stream_if #(.W(WORD_W)) push_s ();
  aofr_stream_if #(.W(WORD_W)) pop_s ();

  // Frame composition from the held conversion
  aofr_frame_pack u_pack (
    .result(hold_result),
    .sup_hi(hold_flags[3]),
    .sup_lo(hold_flags[2]),
    .in_hi(hold_flags[1]),
    .in_lo(hold_flags[0]),
    .value_sel(output_value_selector),
    .supply_sel(supply_alarm_append_sel),
    .input_sel(input_alarm_append_sel),
    .span_append(span_code_append),
    .span_code(span_code),
    .chipid_append(chip_identifier_append),
    .chip_id(chip_id),
    .parity_en(parity_append_enable),
    .frame(pk_frame),
    .len(pk_len),
    .shown(pk_shown)
  );

  // Frame buffer toward the serialiser
  aofr_fifo #(.W(WORD_W), .D(FIFO_DEPTH)) u_fifo (
    .clk(clk),
    .arst_n(arst_n),
    .in_s(push_s),
    .out_s(pop_s),
    .level(fifo_level)
  );

  // Two-stage sync of the application reset pin
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      app_meta <= 1'b0;
      app_sync <= 1'b0;
    end else begin
      app_meta <= app_rst_n;
      app_sync <= app_meta;
    end
  end
  assign app_rst = ~app_sync;

  // Wishbone decode, one request per ack
  assign wb_req = wb_cyc_i & wb_stb_i & ~wb_ack_o;
  assign word_adr = {wb_adr_i[7:2], 2'b00};
  assign wr_frame = wb_req & wb_we_i & (word_adr == OFS_FRAME_CTRL);
  assign wr_range = wb_req & wb_we_i & (word_adr == OFS_RANGE_REF);
  assign wr_chip = wb_req & wb_we_i & (word_adr == OFS_CHIP_ID);

  // Ack one cycle after the request, dropped the next
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) wb_ack_o <= 1'b0;
    else wb_ack_o <= wb_req;
  end

  // Read mux, reserved and unmapped bits read zero
  always_comb begin
    next_rdata = '0;
    case (word_adr)
      OFS_FRAME_CTRL: begin
        next_rdata[FC_CHIPID_BIT] = chip_identifier_append;
        next_rdata[FC_SUPPLY_LSB +: 2] = supply_alarm_append_sel;
        next_rdata[FC_INPUT_LSB +: 2] = input_alarm_append_sel;
        next_rdata[FC_SPAN_BIT] = span_code_append;
        next_rdata[FC_PARITY_BIT] = parity_append_enable;
        next_rdata[FC_VALSEL_LSB +: 3] = output_value_selector;
      end
      OFS_RANGE_REF: begin
        next_rdata[RR_REFOFF_BIT] = onchip_reference_off;
        next_rdata[RR_SPAN_LSB +: 4] = span_code;
      end
      OFS_CHIP_ID: next_rdata[3:0] = chip_id;
      OFS_STATUS: begin
        next_rdata[ST_LVL_LSB +: FIFO_LVL_W] = fifo_level;
        next_rdata[ST_OUTV_BIT] = frame_valid;
        next_rdata[ST_HOLD_BIT] = ~conv_ready;
        next_rdata[ST_APPR_BIT] = app_rst;
      end
      default: next_rdata = '0;
    endcase
  end

  // Read data register
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) wb_dat_o <= '0;
    else if (wb_req) wb_dat_o <= wb_we_i ? 32'h0 : next_rdata;
  end

  // Frame fields cleared by either reset
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      supply_alarm_append_sel <= 2'h0;
      input_alarm_append_sel <= 2'h0;
      span_code_append <= 1'b0;
      output_value_selector <= 3'h0;
      chip_identifier_append <= 1'b0;
    end else if (app_rst) begin
      supply_alarm_append_sel <= 2'h0;
      input_alarm_append_sel <= 2'h0;
      span_code_append <= 1'b0;
      output_value_selector <= 3'h0;
      chip_identifier_append <= 1'b0;
    end else if (wr_frame) begin
      if (wb_sel_i[1]) begin
        chip_identifier_append <= wb_dat_i[FC_CHIPID_BIT];
        supply_alarm_append_sel <= wb_dat_i[FC_SUPPLY_LSB +: 2];
        input_alarm_append_sel <= wb_dat_i[FC_INPUT_LSB +: 2];
        span_code_append <= wb_dat_i[FC_SPAN_BIT];
      end
      if (wb_sel_i[0]) output_value_selector <= wb_dat_i[FC_VALSEL_LSB +: 3];
    end
  end

  // Parity enable survives the application reset
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) parity_append_enable <= 1'b0;
    else if (wr_frame && wb_sel_i[0]) parity_append_enable <= wb_dat_i[FC_PARITY_BIT];
  end

  // Span code, power-on reset only; illegal codes ignored
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) span_code <= SPAN_RST;
    else if (wr_range && wb_sel_i[0] && span_legal(wb_dat_i[RR_SPAN_LSB +: 4])) begin
      span_code <= wb_dat_i[RR_SPAN_LSB +: 4];
    end
  end

  // Reference disable, high turns the onchip reference off
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) onchip_reference_off <= 1'b0;
    else if (app_rst) onchip_reference_off <= 1'b0;
    else if (wr_range && wb_sel_i[0]) onchip_reference_off <= wb_dat_i[RR_REFOFF_BIT];
  end

  // Identifier value appended on request
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) chip_id <= CHIP_ID_RST;
    else if (app_rst) chip_id <= CHIP_ID_RST;
    else if (wr_chip && wb_sel_i[0]) chip_id <= wb_dat_i[3:0];
  end

  // Capture stage; low ready while a frame waits for room
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) conv_ready <= 1'b1;
    else if (conv_valid && conv_ready) conv_ready <= 1'b0;
    else if (push_s.valid && push_s.ready) conv_ready <= 1'b1;
  end

  // Result and flags held with the conversion
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      hold_result <= '0;
      hold_flags <= 4'h0;
    end else if (conv_valid && conv_ready) begin
      hold_result <= conv_result;
      hold_flags <= {supply_high_flag, supply_low_flag, input_high_flag, input_low_flag};
    end
  end

  // Push side of the buffer
  assign push_s.valid = ~conv_ready;
  assign push_s.data = {pk_len, pk_frame};

  // Registered output stage fed from the buffer
  assign pop_s.ready = ~frame_valid | frame_ready;
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      frame_valid <= 1'b0;
      frame_bits <= '0;
      frame_len <= '0;
    end else if (pop_s.ready) begin
      frame_valid <= pop_s.valid;
      if (pop_s.valid) {frame_len, frame_bits} <= pop_s.data;
    end
  end

  // Expected length from the settings, for checking
  assign exp_len = LEN_W'(RES_W + 4 * int'(chip_identifier_append) + 4 * int'(span_code_append)
    + int'(supply_alarm_append_sel[0]) + int'(supply_alarm_append_sel[1])
    + int'(input_alarm_append_sel[0]) + int'(input_alarm_append_sel[1])
    + 2 * int'(parity_append_enable));

  // Checks on the composed frame
  len_sum_a: assert property (@(posedge clk) disable iff (!arst_n)
    push_s.valid |-> pk_len == exp_len)
    else $error("frame length differs from enabled items");
  par_result_a: assert property (@(posedge clk) disable iff (!arst_n)
    push_s.valid && parity_append_enable |-> pk_frame[1] == ^pk_shown)
    else $error("result parity bit wrong");
  par_frame_a: assert property (@(posedge clk) disable iff (!arst_n)
    push_s.valid && parity_append_enable |-> (^{pk_frame[FRAME_W-1:2], pk_frame[0]}) == 1'b0)
    else $error("frame parity not even");
  pass_real_a: assert property (@(posedge clk) disable iff (!arst_n)
    push_s.valid && !output_value_selector[2] |-> pk_shown == hold_result)
    else $error("real result not passed");
  pat_fixed_a: assert property (@(posedge clk) disable iff (!arst_n)
    push_s.valid && output_value_selector[2:1] == 2'b10 |-> pk_shown == {RES_W{output_value_selector[0]}})
    else $error("fixed pattern wrong");
  pat_pairs_a: assert property (@(posedge clk) disable iff (!arst_n)
    push_s.valid && output_value_selector[2:1] == 2'b11
      |-> pk_shown == (output_value_selector[0] ? PAT_ALT2 : PAT_ALT1))
    else $error("alternating pattern wrong");
  ref_off_a: assert property (@(posedge clk) disable iff (!arst_n)
    wr_range && wb_sel_i[0] && !app_rst |=> onchip_reference_off == $past(wb_dat_i[RR_REFOFF_BIT]))
    else $error("reference disable not stored");
  span_legal_a: assert property (@(posedge clk) disable iff (!arst_n)
    span_legal(span_code))
    else $error("span code outside nine ranges");
  app_keep_a: assert property (@(posedge clk) disable iff (!arst_n)
    app_rst && !wb_req |=> $stable(span_code) && $stable(parity_append_enable))
    else $error("power-on fields lost at application reset");
  app_clear_a: assert property (@(posedge clk) disable iff (!arst_n)
    app_rst |=> output_value_selector == 3'h0 && supply_alarm_append_sel == 2'h0 && !onchip_reference_off)
    else $error("application reset left a field set");
  resv_zero_a: assert property (@(posedge clk) disable iff (!arst_n)
    wb_ack_o |-> wb_dat_o[31:16] == 16'h0 && wb_dat_o[9] == 1'b0 && wb_dat_o[15] == 1'b0)
    else $error("reserved bits read nonzero");
  hold_ready_a: assert property (@(posedge clk) disable iff (!arst_n)
    conv_valid && conv_ready |=> !conv_ready && hold_result == $past(conv_result))
    else $error("accepted conversion not held");
  busy_push_a: assert property (@(posedge clk) disable iff (!arst_n)
    !conv_ready && push_s.ready |=> conv_ready)
    else $error("capture stage not freed");
  // Bus handshake, field storage and output stage
  ack_next_a: assert property (@(posedge clk) disable iff (!arst_n)
    wb_req |=> wb_ack_o)
    else $error("request not acknowledged");
  ack_pulse_a: assert property (@(posedge clk) disable iff (!arst_n)
    wb_ack_o |=> !wb_ack_o)
    else $error("ack longer than one cycle");
  wr_rdata_a: assert property (@(posedge clk) disable iff (!arst_n)
    wb_req && wb_we_i |=> wb_dat_o == 32'h0)
    else $error("write returned read data");
  span_ignore_a: assert property (@(posedge clk) disable iff (!arst_n)
    wr_range && !span_legal(wb_dat_i[RR_SPAN_LSB +: 4]) |=> $stable(span_code))
    else $error("illegal span code stored");
  par_store_a: assert property (@(posedge clk) disable iff (!arst_n)
    wr_frame && wb_sel_i[0] |=> parity_append_enable == $past(wb_dat_i[FC_PARITY_BIT]))
    else $error("parity enable not stored");
  id_clear_a: assert property (@(posedge clk) disable iff (!arst_n)
    app_rst |=> chip_id == CHIP_ID_RST && !chip_identifier_append && !span_code_append)
    else $error("identifier fields kept at application reset");
  ref_hold_a: assert property (@(posedge clk) disable iff (!arst_n)
    !wr_range && !app_rst |=> $stable(onchip_reference_off))
    else $error("reference disable changed unasked");
  id_field_a: assert property (@(posedge clk) disable iff (!arst_n)
    push_s.valid && chip_identifier_append |-> pk_frame[pk_len - LEN_W'(16) +: 4] == chip_id)
    else $error("identifier misplaced in frame");
  top_zero_a: assert property (@(posedge clk) disable iff (!arst_n)
    push_s.valid |-> (pk_frame >> pk_len) == '0)
    else $error("bits above frame length set");
  len_range_a: assert property (@(posedge clk) disable iff (!arst_n)
    frame_valid |-> frame_len >= LEN_W'(RES_W) && frame_len <= LEN_W'(FRAME_W))
    else $error("frame length out of range");
  out_hold_a: assert property (@(posedge clk) disable iff (!arst_n)
    frame_valid && !frame_ready |=> frame_valid && $stable(frame_bits) && $stable(frame_len))
    else $error("frame changed before taken");
  fifo_bound_a: assert property (@(posedge clk) disable iff (!arst_n)
    fifo_level <= FIFO_LVL_W'(FIFO_DEPTH))
    else $error("buffer level beyond depth");
endmodule
`default_nettype wire

//--- rtl/aofr_pkg.sv
// Constants and types shared by the output frame and range block
package aofr_pkg;
  localparam int RES_W = 12;
  localparam int FRAME_W = 26;
  localparam int LEN_W = 5;
  localparam int WORD_W = LEN_W + FRAME_W;
  localparam int FIFO_DEPTH = 8;
  localparam int FIFO_LVL_W = $clog2(FIFO_DEPTH + 1);
  // Register byte offsets
  localparam logic [7:0] OFS_FRAME_CTRL = 8'h10;
  localparam logic [7:0] OFS_RANGE_REF = 8'h14;
  localparam logic [7:0] OFS_CHIP_ID = 8'h18;
  localparam logic [7:0] OFS_STATUS = 8'h1c;
  // Field positions
  localparam int FC_CHIPID_BIT = 14;
  localparam int FC_SUPPLY_LSB = 12;
  localparam int FC_INPUT_LSB = 10;
  localparam int FC_SPAN_BIT = 8;
  localparam int FC_PARITY_BIT = 3;
  localparam int FC_VALSEL_LSB = 0;
  localparam int RR_REFOFF_BIT = 6;
  localparam int RR_SPAN_LSB = 0;
  localparam int ST_LVL_LSB = 0;
  localparam int ST_OUTV_BIT = 4;
  localparam int ST_HOLD_BIT = 5;
  localparam int ST_APPR_BIT = 6;
  // Values after reset
  localparam logic [3:0] SPAN_RST = 4'h0;
  localparam logic [3:0] CHIP_ID_RST = 4'h0;
  // Test patterns
  localparam logic [RES_W-1:0] PAT_ALT1 = 12'h555;
  localparam logic [RES_W-1:0] PAT_ALT2 = 12'h333;
  typedef enum logic [2:0] {
    AOFR_VS_ZERO = 3'b100,
    AOFR_VS_ONES = 3'b101,
    AOFR_VS_ALT1 = 3'b110,
    AOFR_VS_ALT2 = 3'b111
  } aofr_valsel_e;
  // Nine legal span codes
  function automatic logic span_legal(input logic [3:0] c);
    return (c <= 4'h4) || (c >= 4'h8 && c <= 4'hb);
  endfunction
endpackage

//--- rtl/aofr_stream_if.sv
// Valid/ready word stream between the block's own modules
`timescale 1ns/100ps
`default_nettype none
interface aofr_stream_if #(parameter int W = 8) ();
  logic valid;
  logic ready;
  logic [W-1:0] data;
  modport src (output valid, output data, input ready);
  modport snk (input valid, input data, output ready);
endinterface
`default_nettype wire

//--- rtl/aofr_fifo.sv
// Word FIFO with valid/ready on both sides
`timescale 1ns/100ps
`default_nettype none
module aofr_fifo #(
  parameter int W = 8,
  parameter int D = 8
) (
  input wire logic clk,
  input wire logic arst_n,
  aofr_stream_if.snk in_s,
  aofr_stream_if.src out_s,
  output logic [$clog2(D+1)-1:0] level
);
  localparam int AW = $clog2(D);
  localparam int LW = $clog2(D + 1);
  localparam logic [LW-1:0] FULL = LW'(D);
  logic [W-1:0] mem [D];
  logic [AW-1:0] wptr;
  logic [AW-1:0] rptr;
  logic push;
  logic pop;
  // Handshake terms
  assign in_s.ready = (level != FULL);
  assign out_s.valid = (level != '0);
  assign out_s.data = mem[rptr];
  assign push = in_s.valid & in_s.ready;
  assign pop = out_s.valid & out_s.ready;
  // Pointers and fill level, depth a power of two
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      wptr <= '0;
      rptr <= '0;
      level <= '0;
    end else begin
      if (push) wptr <= wptr + AW'(1);
      if (pop) rptr <= rptr + AW'(1);
      if (push && !pop) level <= level + LW'(1);
      else if (pop && !push) level <= level - LW'(1);
    end
  end
  // Storage
  always_ff @(posedge clk) begin
    if (push) mem[wptr] <= in_s.data;
  end
endmodule
`default_nettype wire

//--- rtl/aofr_frame_pack.sv
// Builds one output frame from a result and the frame settings
`timescale 1ns/100ps
`default_nettype none
module aofr_frame_pack
  import aofr_pkg::*;
(
  input wire logic [RES_W-1:0] result,
  input wire logic sup_hi,
  input wire logic sup_lo,
  input wire logic in_hi,
  input wire logic in_lo,
  input wire logic [2:0] value_sel,
  input wire logic [1:0] supply_sel,
  input wire logic [1:0] input_sel,
  input wire logic span_append,
  input wire logic [3:0] span_code,
  input wire logic chipid_append,
  input wire logic [3:0] chip_id,
  input wire logic parity_en,
  output logic [FRAME_W-1:0] frame,
  output logic [LEN_W-1:0] len,
  output logic [RES_W-1:0] shown
);
  logic rpar;
  logic fpar;
  // Result value or test pattern
  always_comb begin
    case (value_sel)
      AOFR_VS_ZERO: shown = '0;
      AOFR_VS_ONES: shown = '1;
      AOFR_VS_ALT1: shown = PAT_ALT1;
      AOFR_VS_ALT2: shown = PAT_ALT2;
      default: shown = result;
    endcase
  end
  // Appends items after the result, newest at the low end
  always_comb begin
    frame = FRAME_W'(shown);
    len = LEN_W'(RES_W);
    rpar = 1'b0;
    fpar = 1'b0;
    if (chipid_append) begin
      frame = {frame[FRAME_W-5:0], chip_id};
      len = len + 5'h4;
    end
    if (supply_sel[0]) begin
      frame = {frame[FRAME_W-2:0], sup_hi};
      len = len + 5'h1;
    end
    if (supply_sel[1]) begin
      frame = {frame[FRAME_W-2:0], sup_lo};
      len = len + 5'h1;
    end
    if (input_sel[0]) begin
      frame = {frame[FRAME_W-2:0], in_hi};
      len = len + 5'h1;
    end
    if (input_sel[1]) begin
      frame = {frame[FRAME_W-2:0], in_lo};
      len = len + 5'h1;
    end
    if (span_append) begin
      frame = {frame[FRAME_W-5:0], span_code};
      len = len + 5'h4;
    end
    if (parity_en) begin
      rpar = ^shown;
      fpar = ^frame;
      frame = {frame[FRAME_W-3:0], rpar, fpar};
      len = len + 5'h2;
    end
  end
endmodule
`default_nettype wire

//--- verification/aofr_host_model.sv
// Host model that takes frames off the output and unpacks them bit by bit
`timescale 1ns/100ps
`default_nettype none
module aofr_host_model
  import aofr_pkg::*;
(
  input wire logic clk,
  input wire logic arst_n,
  input wire logic stall,
  input wire logic frame_valid,
  input wire logic [FRAME_W-1:0] frame_bits,
  input wire logic [LEN_W-1:0] frame_len,
  output logic frame_ready,
  output logic got,
  output logic [FRAME_W-1:0] got_raw,
  output logic [FRAME_W-1:0] got_serial,
  output logic [LEN_W-1:0] got_len
);
  logic [FRAME_W-1:0] acc;
  // Ready follows the stall request one cycle late
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      frame_ready <= 1'b0;
    end else begin
      frame_ready <= !stall;
    end
  end
  // Clock out exactly frame_len bits, first bit from the top
  always_comb begin
    acc = '0;
    for (int k = FRAME_W - 1; k >= 0; k--) begin
      if (k < frame_len) begin
        acc = {acc[FRAME_W-2:0], frame_bits[k]};
      end
    end
  end
  // Keep each frame taken for the bench
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      got <= 1'b0;
      got_raw <= '0;
      got_serial <= '0;
      got_len <= '0;
    end else begin
      got <= frame_valid && frame_ready;
      if (frame_valid && frame_ready) begin
        got_raw <= frame_bits;
        got_serial <= acc;
        got_len <= frame_len;
      end
    end
  end
endmodule
`default_nettype wire

//--- verification/testbench.sv
// Self-checking bench for the output frame and range block
`timescale 1ns/100ps
`default_nettype none
module testbench
  import aofr_pkg::*;
;
  logic clk, arst_n, app_rst_n, wb_cyc, wb_stb, wb_we, wb_ack;
  logic [7:0] wb_adr;
  logic [3:0] wb_sel, flags, id_v, span_v;
  logic [31:0] wb_wdat, wb_rdat, ctrl_v, rdv;
  logic conv_valid, conv_ready, frame_valid, frame_ready, ref_off, stall, got, ok;
  logic [RES_W-1:0] conv_result;
  logic [FRAME_W-1:0] frame_bits, got_raw, got_serial;
  logic [LEN_W-1:0] frame_len, got_len;
  logic [3:0] span_code;
  logic [FRAME_W-1:0] exp_q[$];
  logic [LEN_W-1:0] len_q[$];
  int fails, samples_checked, cycles, acc_n;

  aofr_top u_aofr_top (.clk(clk), .arst_n(arst_n), .app_rst_n(app_rst_n), .wb_cyc_i(wb_cyc), .wb_stb_i(wb_stb),
    .wb_we_i(wb_we), .wb_adr_i(wb_adr), .wb_sel_i(wb_sel), .wb_dat_i(wb_wdat), .wb_dat_o(wb_rdat),
    .wb_ack_o(wb_ack), .conv_valid(conv_valid), .conv_result(conv_result), .supply_high_flag(flags[3]),
    .supply_low_flag(flags[2]), .input_high_flag(flags[1]), .input_low_flag(flags[0]),
    .conv_ready(conv_ready), .frame_valid(frame_valid), .frame_bits(frame_bits), .frame_len(frame_len),
    .frame_ready(frame_ready), .onchip_reference_off(ref_off), .span_code(span_code));
  aofr_host_model u_aofr_host_model (.clk(clk), .arst_n(arst_n), .stall(stall), .frame_valid(frame_valid),
    .frame_bits(frame_bits), .frame_len(frame_len), .frame_ready(frame_ready), .got(got), .got_raw(got_raw),
    .got_serial(got_serial), .got_len(got_len));

  // Free-running clock
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  task automatic complete_run;
    $display("Comparisons %0d, mismatches %0d", samples_checked, fails);
    if (fails == 0 && samples_checked > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  task automatic check(input logic [31:0] got_v, input logic [31:0] exp_v);
    samples_checked++;
    if (got_v !== exp_v) begin
      fails++;
      $display("ERROR %0t: got %h expected %h", $time, got_v, exp_v);
    end
  endtask

  // One classic Wishbone cycle, waits for ack without assuming a latency
  task automatic wb_xfer(input logic we, input logic [7:0] adr, input logic [31:0] dat, output logic [31:0] rd);
    wb_cyc <= 1'b1;
    wb_stb <= 1'b1;
    wb_we <= we;
    wb_adr <= adr;
    wb_wdat <= dat;
    do begin
      @(posedge clk);
    end while (wb_ack !== 1'b1);
    rd = wb_rdat;
    wb_cyc <= 1'b0;
    wb_stb <= 1'b0;
    wb_we <= 1'b0;
    @(posedge clk);
  endtask

  task automatic wr(input logic [7:0] adr, input logic [31:0] dat);
    logic [31:0] dummy;
    wb_xfer(1'b1, adr, dat, dummy);
  endtask

  // Frame the block should send for a result under the current settings
  function automatic void expect_frame(input logic [RES_W-1:0] res, input logic [3:0] fl,
      output logic [FRAME_W-1:0] f, output logic [LEN_W-1:0] n);
    logic [RES_W-1:0] v;
    logic [31:0] a;
    int k;
    case (ctrl_v[2:0])
      3'b100: v = 12'h000;
      3'b101: v = 12'hfff;
      3'b110: v = PAT_ALT1;
      3'b111: v = PAT_ALT2;
      default: v = res;
    endcase
    a = 32'(v);
    k = RES_W;
    if (ctrl_v[14]) begin
      a = {a[27:0], id_v};
      k += 4;
    end
    if (ctrl_v[12]) begin
      a = {a[30:0], fl[3]};
      k += 1;
    end
    if (ctrl_v[13]) begin
      a = {a[30:0], fl[2]};
      k += 1;
    end
    if (ctrl_v[10]) begin
      a = {a[30:0], fl[1]};
      k += 1;
    end
    if (ctrl_v[11]) begin
      a = {a[30:0], fl[0]};
      k += 1;
    end
    if (ctrl_v[8]) begin
      a = {a[27:0], span_v};
      k += 4;
    end
    if (ctrl_v[3]) begin
      a = {a[29:0], ^v, ^a};
      k += 2;
    end
    f = a[FRAME_W-1:0];
    n = LEN_W'(k);
  endfunction

  // Offer a conversion; gives up after lim edges, so a full buffer shows as not taken
  task automatic conv(input logic [RES_W-1:0] res, input logic [3:0] fl, input int lim, output logic taken);
    logic [FRAME_W-1:0] f;
    logic [LEN_W-1:0] n;
    int w;
    expect_frame(res, fl, f, n);
    conv_valid <= 1'b1;
    conv_result <= res;
    flags <= fl;
    w = 0;
    do begin
      @(posedge clk);
      w++;
      taken = (conv_ready === 1'b1);
    end while (!taken && w < lim);
    conv_valid <= 1'b0;
    if (taken) begin
      exp_q.push_back(f);
      len_q.push_back(n);
    end
    @(posedge clk);
  endtask

  task automatic drain;
    int w;
    w = 0;
    while (exp_q.size() != 0 && w < 400) begin
      @(posedge clk);
      w++;
    end
    check(32'(exp_q.size()), 32'h0);
  endtask

  // Compare every frame the host takes against the expected queue
  always @(posedge clk) begin
    if (got === 1'b1) begin
      if (exp_q.size() == 0) begin
        fails++;
        $display("ERROR %0t: unexpected frame", $time);
      end else begin
        check(32'(got_raw), 32'(exp_q[0]));
        check(32'(got_serial), 32'(exp_q[0]));
        check(32'(got_len), 32'(len_q[0]));
        void'(exp_q.pop_front());
        void'(len_q.pop_front());
      end
    end
  end

  // Hang guard
  always @(posedge clk) begin
    cycles++;
    if (cycles == 20000) begin
      fails++;
      complete_run();
    end
  end

  initial begin
    arst_n = 1'b0;
    app_rst_n = 1'b1;
    {wb_cyc, wb_stb, wb_we, conv_valid, stall} = '0;
    wb_adr = 8'h00;
    wb_sel = 4'hf;
    wb_wdat = 32'h0;
    conv_result = '0;
    flags = 4'h0;
    {fails, samples_checked, cycles} = '0;
    {ctrl_v, id_v, span_v} = '0;
    repeat (12) @(posedge clk);
    arst_n <= 1'b1;
    repeat (4) @(posedge clk);
    // Values after power-on and an unmapped address
    wb_xfer(1'b0, OFS_FRAME_CTRL, 32'h0, rdv);
    check(rdv, 32'h0);
    wb_xfer(1'b0, OFS_RANGE_REF, 32'h0, rdv);
    check(rdv, 32'h0);
    wb_xfer(1'b0, 8'h04, 32'h0, rdv);
    check(rdv, 32'h0);
    // Reserved bits take no writes
    wr(OFS_FRAME_CTRL, 32'hffff_ffff);
    wb_xfer(1'b0, OFS_FRAME_CTRL, 32'h0, rdv);
    check(rdv, 32'h0000_7d0f);
    wr(OFS_RANGE_REF, 32'hffff_ffcb);
    wb_xfer(1'b0, OFS_RANGE_REF, 32'h0, rdv);
    check(rdv, 32'h0000_004b);
    check(32'(ref_off), 32'h1);
    // Every span code, illegal ones keep the last legal span
    for (int i = 0; i < 16; i++) begin
      wr(OFS_RANGE_REF, 32'(i));
      if (i <= 4 || (i >= 8 && i <= 11)) span_v = 4'(i);
      check(32'(span_code), 32'(span_v));
    end
    check(32'(ref_off), 32'h0);
    // Frame contents over all selector codes and append mixes
    wr(OFS_CHIP_ID, 32'h0000_000a);
    id_v = 4'ha;
    for (int i = 0; i < 16; i++) begin
      ctrl_v = {17'h0, i[2], i[1:0], i[3:2], 1'b0, i[3], 4'h0, i[0], i[2:0]};
      wr(OFS_FRAME_CTRL, ctrl_v);
      conv(12'h9c5 ^ 12'(i * 291), 4'(i) ^ 4'h5, 40, ok);
      check(32'(ok), 32'h1);
    end
    drain();
    // Host stalls until the buffer refuses, then drains it
    ctrl_v = 32'h0000_7d08;
    wr(OFS_FRAME_CTRL, ctrl_v);
    stall <= 1'b1;
    acc_n = 0;
    for (int i = 0; i < 12; i++) begin
      conv(12'(i * 7 + 100), 4'(i), 30, ok);
      if (ok) acc_n++;
    end
    wb_xfer(1'b0, OFS_STATUS, 32'h0, rdv);
    check(rdv, 32'h0000_0038);
    check(32'(acc_n), 32'd10);
    stall <= 1'b0;
    drain();
    // Application reset keeps span and parity only
    wr(OFS_RANGE_REF, 32'h0000_0049);
    span_v = 4'h9;
    app_rst_n <= 1'b0;
    repeat (3) @(posedge clk);
    wb_xfer(1'b0, OFS_STATUS, 32'h0, rdv);
    check(rdv, 32'h0000_0040);
    app_rst_n <= 1'b1;
    repeat (6) @(posedge clk);
    wb_xfer(1'b0, OFS_FRAME_CTRL, 32'h0, rdv);
    check(rdv, 32'h0000_0008);
    wb_xfer(1'b0, OFS_RANGE_REF, 32'h0, rdv);
    check(rdv, 32'h0000_0009);
    wb_xfer(1'b0, OFS_CHIP_ID, 32'h0, rdv);
    check(rdv, 32'h0);
    ctrl_v = 32'h0000_0008;
    id_v = 4'h0;
    conv(12'h7e1, 4'hf, 40, ok);
    drain();
    complete_run();
  end
endmodule
`default_nettype wire
